// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
  localparam integer PS = 2;
  localparam integer HOLD = 4;
  logic        clock = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0, r;
  logic        st_i = 1'b0, sr_i = 1'b0, wi_i = 1'b0, wr_i = 1'b0, osr = 1'b0, sys_t = 1'b0, osc_t = 1'b0;
  logic [7:0]  rnd = 8'h3D;
  logic [1:0]  st = 2'h0, msk = 2'h0;
  wire  [31:0] rdat;
  wire  [15:0] vlo, vhi;
  wire         ack, stop_m, wait_m, orun, ofon, irst, vload, irq;
  int          fail_count = 0, checks_done = 0, cyc_n = 0;
  wdt_top #(.PRESCALE_SLOW(PS), .PRESCALE_FAST(1), .HOLD_CYCLES(HOLD)) u_wdt_top (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sys_tick(sys_t), .osc_tick(osc_t), .stop_instruction(st_i), .stop_release(sr_i),
    .wait_instruction(wi_i), .wait_release(wr_i), .osc_stop_request(osr),
    .stop_mode(stop_m), .wait_mode(wait_m), .osc_run(orun), .osc_force_on(ofon),
    .internal_reset(irst), .vector_load(vload), .vector_lo_addr(vlo),
    .vector_hi_addr(vhi), .irq(irq));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  always #4 clock = ~clock;
  always @(posedge clock) begin
    rnd <= lfsr(rnd);
    sys_t <= rnd[0];
    osc_t <= rnd[1];
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      fail_count++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rst;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    st = 2'h0;
    msk = 2'h0;
  endtask
  // A missing ack is ended only by the cycle timeout.
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    r = rdat;
    {cyc, stb} <= 2'b00;
    if (w && a == 4'h4) st = st & ~d[1:0];
    if (w && a == 4'h8) msk = d[1:0];
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h0);
    `CHK(r, {24'h0, e})
  endtask
  task automatic irqc;
    @(negedge clock);
    `CHK(irq, |(st & msk))
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    {st_i, sr_i, wi_i, wr_i} <= 4'b1000 >> k;
    @(posedge clock);
    {st_i, sr_i, wi_i, wr_i} <= 4'b0000;
  endtask
  // Counts selected ticks outside stop mode until the internal reset rises.
  task automatic run(input logic osc, input int n);
    int k, c;
    k = 0;
    c = 0;
    while (irst !== 1'b1 && c < 4000) begin
      @(posedge clock);
      c++;
      if ((osc ? osc_t : sys_t) && !stop_m) k++;
    end
    `CHK(k >= n - 4 && k <= n + 2, 1'b1)
    st[0] = 1'b1;
    repeat (HOLD - 1) @(posedge clock);
    @(negedge clock);
    `CHK({irst, vload}, 2'b01)
    repeat (3) @(posedge clock);
  endtask
  initial begin
    rst;
    rd(4'h0, 8'h1F);
    rd(4'h4, 8'h00);
    rd(4'hC, 8'h00);
    `CHK({vhi, vlo}, 32'hFFFD_FFFC)
    repeat (600) @(posedge clock);
    `CHK(irst, 1'b0)
    $display("idle test done");
    wb(1'b1, 4'h0, 8'h00);
    repeat (3) begin
      repeat (300) @(posedge clock);
      wb(1'b1, 4'h0, 8'hE0);
    end
    `CHK(irst, 1'b0)
    rd(4'h0, 8'h1F);
    run(1'b0, PS * 256);
    rd(4'h0, 8'h1F);
    rd(4'h4, 8'h01);
    wb(1'b1, 4'h8, 8'h01);
    irqc;
    wb(1'b1, 4'h4, 8'h01);
    irqc;
    $display("underflow test done");
    rst;
    wb(1'b1, 4'h0, 8'h40);
    rd(4'h0, 8'h5F);
    wb(1'b1, 4'h0, 8'h00);
    rd(4'h0, 8'h5F);
    pulse(0);
    @(negedge clock);
    `CHK(irst, 1'b1)
    st[1] = 1'b1;
    repeat (HOLD + 3) @(posedge clock);
    rd(4'h4, 8'h02);
    wb(1'b1, 4'h8, 8'h02);
    irqc;
    $display("stop reset test done");
    rst;
    wb(1'b1, 4'h0, 8'h80);
    fork
      run(1'b0, 256);
      begin
        pulse(0);
        @(negedge clock);
        `CHK(stop_m, 1'b1)
        repeat (600) @(posedge clock);
        `CHK(irst, 1'b0)
        rd(4'h4, 8'h00);
        pulse(1);
        pulse(2);
        @(negedge clock);
        `CHK(wait_m, 1'b1)
        pulse(3);
        @(negedge clock);
        `CHK(wait_m, 1'b0)
      end
    join
    $display("stop wait test done");
    rst;
    osr <= 1'b1;
    @(negedge clock);
    `CHK(orun, 1'b0)
    wb(1'b1, 4'h0, 8'h60);
    rd(4'h0, 8'h7F);
    `CHK(ofon, 1'b1)
    `CHK(orun, 1'b1)
    run(1'b1, PS * 256);
    $display("osc test done");
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire

// file: wdt_counter.v
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.vh"

module wdt_counter #(
  parameter integer PRESCALE_SLOW = `WDT_PRESCALE_SLOW,
  parameter integer PRESCALE_FAST = `WDT_PRESCALE_FAST,
  parameter integer PRE_WIDTH     = 16
) (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       reload,
  input  wire       run,
  input  wire       src_tick,
  input  wire       fast_sel,
  output wire [7:0] count,
  output reg        underflow
);

  reg  [PRE_WIDTH-1:0] pre_q;
  reg  [7:0]           cnt_q;
  wire [PRE_WIDTH-1:0] pre_last;
  wire                 pre_done;

  assign pre_last = fast_sel ? PRESCALE_FAST[PRE_WIDTH-1:0] - 1'b1 : PRESCALE_SLOW[PRE_WIDTH-1:0] - 1'b1;
  assign pre_done = run && src_tick && (pre_q >= pre_last);
  assign count    = cnt_q;

  // The prescaler feeds the eight-bit down counter; a reload restarts both.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_q     <= {PRE_WIDTH{1'b0}};
      cnt_q     <= `WDT_CNT_RESET;
      underflow <= 1'b0;
    end else begin
      underflow <= 1'b0;
      if (reload) begin
        pre_q <= {PRE_WIDTH{1'b0}};
        cnt_q <= `WDT_CNT_RESET;
      end else if (run && src_tick) begin
        if (pre_done) begin
          pre_q <= {PRE_WIDTH{1'b0}};
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            underflow <= 1'b1;
          end
        end else begin
          pre_q <= pre_q + 1'b1;
        end
      end
    end
  end

endmodule // wdt_counter

`default_nettype wire

// file: wdt_map.vh
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// Register byte offsets on the bus.
`define WDT_OFS_CTRL        4'h0
`define WDT_OFS_IRQ_STATUS  4'h4
`define WDT_OFS_IRQ_MASK    4'h8

// Control register field positions.
`define WDT_CTRL_CNT_LSB    0
`define WDT_CTRL_CNT_MSB    4
`define WDT_CTRL_OSC_SEL    5
`define WDT_CTRL_STOP_RST   6
`define WDT_CTRL_SRC_SEL    7

// Interrupt status and mask bit positions.
`define WDT_IRQ_UNDERFLOW   0
`define WDT_IRQ_STOP_RESET  1
`define WDT_IRQ_BITS        2

// Reset values.
`define WDT_CNT_RESET       8'hFF
`define WDT_CTRL_RESET      3'h0
`define WDT_MASK_RESET      2'h0

// Underflow interval: 32.768 ms at an 8 MHz count source.
`define WDT_T_UNDERFLOW_US  32768
`define WDT_F_XIN_KHZ       8000
`define WDT_UNDERFLOW_TICKS (`WDT_T_UNDERFLOW_US * `WDT_F_XIN_KHZ / 1000)
`define WDT_CNT_WIDTH       8
`define WDT_PRESCALE_SLOW   (`WDT_UNDERFLOW_TICKS / 256)
`define WDT_PRESCALE_FAST   16

// Internal reset hold time and its cycle count at 8 ns.
`define WDT_CLK_PERIOD_NS   8
`define WDT_T_RST_HOLD_NS   2000
`define WDT_RST_HOLD_CYCLES ((`WDT_T_RST_HOLD_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)

// Reset vector locations.
`define WDT_VEC_LO_ADDR     16'hFFFC
`define WDT_VEC_HI_ADDR     16'hFFFD

`endif

// file: wdt_reset_gen.v
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.vh"

module wdt_reset_gen #(
  parameter integer HOLD_CYCLES = `WDT_RST_HOLD_CYCLES,
  parameter integer HOLD_WIDTH  = 16
) (
  input  wire clock,
  input  wire rst_n,
  input  wire trigger,
  output reg  internal_reset,
  output reg  vector_load
);

  reg [HOLD_WIDTH-1:0] hold_q;

  // The reset stays high for the hold time, then one pulse asks for the vector fetch.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_q         <= {HOLD_WIDTH{1'b0}};
      internal_reset <= 1'b0;
      vector_load    <= 1'b0;
    end else begin
      vector_load <= 1'b0;
      if (trigger && !internal_reset) begin
        internal_reset <= 1'b1;
        hold_q         <= HOLD_CYCLES[HOLD_WIDTH-1:0] - 1'b1;
      end else if (internal_reset) begin
        if (hold_q == {HOLD_WIDTH{1'b0}}) begin
          internal_reset <= 1'b0;
          vector_load    <= 1'b1;
        end else begin
          hold_q <= hold_q - 1'b1;
        end
      end
    end
  end

endmodule // wdt_reset_gen

`default_nettype wire

// file: wdt_top.v
// Notes on behaviour
// - After reset the counter stays stopped until software first writes control.
// - Underflow raises an internal reset; afterwards execution resumes from the reset vector.
// - Control read gives counter bits 7..3 low, then osc select, stop select, source select.
// - Stop select at 0 lets stop instruction enter stop mode; counting resumes on release.
// - The wait instruction does not halt the counter.
// - Stop select at 1 turns the stop instruction into an internal reset.
// - Stop select clears on reset and cannot be cleared again by software.
// - With source select 0 the interval is 262144 count-source ticks.
// - Counting continues during stop-release stabilising wait and wait mode.
// - Selecting the on-chip oscillator forces it on and ignores stop requests.
// - After any reset the program counter loads the vector at FFFD/FFFC.
// - Reset and every control write reload the counter to all ones.
// - Control bits 7..5 are writable once after reset, zero after reset.
// - The count chain is built around an eight-bit counter.
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.vh"

module wdt_top #(
  parameter integer PRESCALE_SLOW = `WDT_PRESCALE_SLOW,
  parameter integer PRESCALE_FAST = `WDT_PRESCALE_FAST,
  parameter integer HOLD_CYCLES   = `WDT_RST_HOLD_CYCLES
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        sys_tick,
  input  wire        osc_tick,
  input  wire        stop_instruction,
  input  wire        stop_release,
  input  wire        wait_instruction,
  input  wire        wait_release,
  input  wire        osc_stop_request,
  output reg         stop_mode,
  output reg         wait_mode,
  output wire        osc_run,
  output wire        osc_force_on,
  output wire        internal_reset,
  output wire        vector_load,
  output wire [15:0] vector_lo_addr,
  output wire [15:0] vector_hi_addr,
  output wire        irq
);

  reg                      running_q;
  reg                      locked_q;
  reg                      src_sel_q;
  reg                      stop_rst_q;
  reg                      osc_sel_q;
  reg  [`WDT_IRQ_BITS-1:0] status_q;
  reg  [`WDT_IRQ_BITS-1:0] mask_q;
  reg  [`WDT_IRQ_BITS-1:0] status_d;
  reg  [31:0]              rdata_d;
  wire                     req;
  wire                     wr_now;
  wire                     wr_ctrl;
  wire                     wr_status;
  wire                     wr_mask;
  wire                     count_run;
  wire                     tick;
  wire                     underflow;
  wire                     stop_reset;
  wire                     reset_trigger;
  wire [7:0]               count;
  wire [7:0]               ctrl_rd;

  // Bus slave: one wait state, then ack for a single cycle.
  assign req       = wb_cyc_i && wb_stb_i;
  assign wr_now    = req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign wr_ctrl   = wr_now && (wb_adr_i == `WDT_OFS_CTRL);
  assign wr_status = wr_now && (wb_adr_i == `WDT_OFS_IRQ_STATUS);
  assign wr_mask   = wr_now && (wb_adr_i == `WDT_OFS_IRQ_MASK);

  assign ctrl_rd = {src_sel_q, stop_rst_q, osc_sel_q, count[7:3]};

  always @* begin
    rdata_d = 32'h0000_0000;
    case (wb_adr_i)
      `WDT_OFS_CTRL: begin
        rdata_d[7:0] = ctrl_rd;
      end
      `WDT_OFS_IRQ_STATUS: begin
        rdata_d[`WDT_IRQ_BITS-1:0] = status_q;
      end
      `WDT_OFS_IRQ_MASK: begin
        rdata_d[`WDT_IRQ_BITS-1:0] = mask_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= rdata_d;
      end
    end
  end

  // Control state. The internal reset clears it like a power-on reset.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      running_q  <= 1'b0;
      locked_q   <= 1'b0;
      src_sel_q  <= 1'b0;
      stop_rst_q <= 1'b0;
      osc_sel_q  <= 1'b0;
    end else if (internal_reset) begin
      running_q  <= 1'b0;
      locked_q   <= 1'b0;
      src_sel_q  <= 1'b0;
      stop_rst_q <= 1'b0;
      osc_sel_q  <= 1'b0;
    end else if (wr_ctrl) begin
      running_q <= 1'b1;
      locked_q  <= 1'b1;
      if (!locked_q) begin
        src_sel_q  <= wb_dat_i[`WDT_CTRL_SRC_SEL];
        stop_rst_q <= wb_dat_i[`WDT_CTRL_STOP_RST];
        osc_sel_q  <= wb_dat_i[`WDT_CTRL_OSC_SEL];
      end
    end
  end

  // Low-power modes. Stop halts the chain; wait does not.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stop_mode <= 1'b0;
      wait_mode <= 1'b0;
    end else if (internal_reset) begin
      stop_mode <= 1'b0;
      wait_mode <= 1'b0;
    end else begin
      if (stop_release) begin
        stop_mode <= 1'b0;
      end else if (stop_instruction && !stop_rst_q) begin
        stop_mode <= 1'b1;
      end
      if (wait_release) begin
        wait_mode <= 1'b0;
      end else if (wait_instruction) begin
        wait_mode <= 1'b1;
      end
    end
  end

  // Wait mode and the post-release stabilising wait leave the counter running.
  assign count_run = running_q && !stop_mode && !internal_reset;
  assign tick      = osc_sel_q ? osc_tick : sys_tick;

  assign osc_force_on = osc_sel_q;
  assign osc_run      = osc_sel_q || !osc_stop_request;

  wdt_counter #(
    .PRESCALE_SLOW (PRESCALE_SLOW),
    .PRESCALE_FAST (PRESCALE_FAST),
    .PRE_WIDTH     (16)
  ) u_counter (
    .clock     (clock),
    .rst_n     (rst_n),
    .reload    (wr_ctrl || internal_reset),
    .run       (count_run),
    .src_tick  (tick),
    .fast_sel  (src_sel_q),
    .count     (count),
    .underflow (underflow)
  );

  assign stop_reset    = stop_instruction && stop_rst_q && !internal_reset;
  assign reset_trigger = underflow || stop_reset;

  wdt_reset_gen #(
    .HOLD_CYCLES (HOLD_CYCLES),
    .HOLD_WIDTH  (16)
  ) u_reset_gen (
    .clock          (clock),
    .rst_n          (rst_n),
    .trigger        (reset_trigger),
    .internal_reset (internal_reset),
    .vector_load    (vector_load)
  );

  assign vector_lo_addr = `WDT_VEC_LO_ADDR;
  assign vector_hi_addr = `WDT_VEC_HI_ADDR;

  // Sticky event flags; a new event wins over a write-one-to-clear.
  always @* begin
    status_d = status_q;
    if (wr_status) begin
      status_d = status_q & ~wb_dat_i[`WDT_IRQ_BITS-1:0];
    end
    if (underflow) begin
      status_d[`WDT_IRQ_UNDERFLOW] = 1'b1;
    end
    if (stop_reset) begin
      status_d[`WDT_IRQ_STOP_RESET] = 1'b1;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= {`WDT_IRQ_BITS{1'b0}};
      mask_q   <= `WDT_MASK_RESET;
    end else begin
      status_q <= status_d;
      if (wr_mask) begin
        mask_q <= wb_dat_i[`WDT_IRQ_BITS-1:0];
      end
    end
  end

  assign irq = |(status_q & mask_q);

endmodule // wdt_top

`default_nettype wire

// file: wdt_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module wdt_top_properties #(
  parameter integer HOLD_CYCLES = 4
) (
  input wire        clock,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        stop_instruction,
  input wire        wait_instruction,
  input wire        osc_stop_request,
  input wire        stop_mode,
  input wire        wait_mode,
  input wire        osc_run,
  input wire        osc_force_on,
  input wire        internal_reset,
  input wire        vector_load,
  input wire [15:0] vector_lo_addr,
  input wire [15:0] vector_hi_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Counts how long the internal reset has been held.
  logic [15:0] hold_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) hold_q <= 16'h0;
    else hold_q <= internal_reset ? hold_q + 16'h1 : 16'h0;
  end
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read upper bits");
  vector_addr_a: assert property (vector_lo_addr == 16'hFFFC && vector_hi_addr == 16'hFFFD)
    else $error("vector address");
  osc_enable_a: assert property (osc_run == (osc_force_on || !osc_stop_request))
    else $error("osc enable");
  hold_time_a: assert property ($fell(internal_reset) |-> hold_q == HOLD_CYCLES)
    else $error("hold time");
  vector_pulse_a: assert property ($fell(internal_reset) |-> ##[0:1] (vector_load ##1 !vector_load))
    else $error("vector load");
  stop_entry_a: assert property ($rose(stop_mode) |-> $past(stop_instruction))
    else $error("stop entry");
  wait_entry_a: assert property ($rose(wait_mode) |-> $past(wait_instruction))
    else $error("wait entry");
endmodule // wdt_top_properties
bind wdt_top wdt_top_properties #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (
  .clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
  .stop_instruction, .wait_instruction, .osc_stop_request, .stop_mode,
  .wait_mode, .osc_run, .osc_force_on, .internal_reset, .vector_load,
  .vector_lo_addr, .vector_hi_addr);
`default_nettype wire
